/* dv/fwf_net_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Network side: sends received frames into the block.
module fwf_net_model (
  // Clock
  input wire logic clk_i,
  // Receive stream
  output logic valid_o,
  output logic [7:0] data_o,
  output logic sof_o,
  output logic eof_o,
  output logic fcs_ok_o,
  output logic [3:0] hit_o
);
  logic [7:0] byte_r = 8'h00;
  logic [7:0] idle_r = 8'h00;
  logic fcs_r = 1'b0;
  logic [3:0] hit_r = 4'h0;

  initial begin
    valid_o = 1'b0;
    sof_o = 1'b0;
    eof_o = 1'b0;
  end

  // Outside a valid byte the lines carry a pattern that moves every cycle,
  // so a design sampling them at the wrong time cannot pass by luck.
  always @(posedge clk_i) begin
    idle_r <= idle_r + 8'h35;
  end
  assign data_o = valid_o ? byte_r : idle_r;
  assign fcs_ok_o = (valid_o && eof_o) ? fcs_r : idle_r[0];
  assign hit_o = valid_o ? hit_r : idle_r[7:4];

  // A slow sender leaves a gap of one idle cycle every eight bytes.
  task automatic send(input logic [7:0] f [64], input logic fcs, input logic [3:0] hit,
                      input logic slow);
    for (int i = 0; i < 64; i++) begin
      if (slow && i[2:0] == 3'h3) begin
        @(posedge clk_i);
        valid_o <= 1'b0;
        sof_o <= 1'b0;
        eof_o <= 1'b0;
      end
      @(posedge clk_i);
      valid_o <= 1'b1;
      byte_r <= f[i];
      sof_o <= (i == 0);
      eof_o <= (i == 63);
      fcs_r <= fcs;
      hit_r <= hit;
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    sof_o <= 1'b0;
    eof_o <= 1'b0;
  endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`include "fwf_consts.svh"
// ==========================================================
// Bench for the fixed wake filter.
module tb;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [1:0] kind;
    logic [7:0] op;
    logic [7:0] iph;
    logic fcs;
    logic [3:0] hit;
    logic wake;
  } fwf_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_rst_n_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic aux_power_sense_i = 1'b1;
  logic wake_on_lan_setting_i = 1'b0;
  logic ucode_active_i = 1'b0;
  logic host_clk_run_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pme_n_o, engine_pass_o, engine_store_o;
  logic rx_valid, rx_sof, rx_eof, rx_fcs;
  logic [7:0] rx_data;
  logic [3:0] rx_hit;
  int fail_count = 0;
  int compares = 0;
  int pass_cnt = 0;
  int store_cnt = 0;
  logic [7:0] frm [64];
  logic [31:0] rd;
  // Hit bits: 0 unicast, 1 group, 2 broadcast, 3 wake pattern.
  fwf_row_t rows [15] = '{
    '{5'h01, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h1, 1'b1},
    '{5'h02, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h1, 1'b0},
    '{5'h02, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h2, 1'b1},
    '{5'h1f, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b0},
    '{5'h10, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h8, 1'b1},
    '{5'h0f, 2'h0, 8'h01, 8'h5a, 1'b1, 4'h8, 1'b0},
    '{5'h04, 2'h1, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b1},
    '{5'h04, 2'h1, 8'h01, 8'h5a, 1'b0, 4'h4, 1'b0},
    '{5'h04, 2'h1, 8'h02, 8'h5a, 1'b1, 4'h4, 1'b0},
    '{5'h04, 2'h1, 8'h01, 8'h5b, 1'b1, 4'h4, 1'b0},
    '{5'h04, 2'h2, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b0},
    '{5'h0c, 2'h2, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b1},
    '{5'h0c, 2'h1, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b1},
    '{5'h04, 2'h3, 8'h01, 8'h5a, 1'b1, 4'h4, 1'b0},
    '{5'h01, 2'h0, 8'h01, 8'h5a, 1'b0, 4'h1, 1'b0}
  };

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (engine_pass_o === 1'b1) pass_cnt++;
    if (engine_store_o === 1'b1) store_cnt++;
  end

  fwf_net_model net_u (.clk_i(clk_i), .valid_o(rx_valid), .data_o(rx_data), .sof_o(rx_sof),
    .eof_o(rx_eof), .fcs_ok_o(rx_fcs), .hit_o(rx_hit));
  fwf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_rst_n_i(bus_rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_sof_i(rx_sof), .rx_eof_i(rx_eof),
    .rx_fcs_ok_i(rx_fcs), .rx_ia_match_i(rx_hit[0]), .rx_mc_match_i(rx_hit[1]),
    .rx_bc_match_i(rx_hit[2]), .rx_pattern_match_i(rx_hit[3]),
    .aux_power_sense_i(aux_power_sense_i), .wake_on_lan_setting_i(wake_on_lan_setting_i),
    .ucode_active_i(ucode_active_i), .host_clk_run_i(host_clk_run_i),
    .pme_n_o(pme_n_o), .engine_pass_o(engine_pass_o), .engine_store_o(engine_store_o));

  // ==========================================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no bus answer");
  endtask

  task automatic por(input logic sense, input logic wake_on_lan_setting);
    @(posedge clk_i);
    rst_i <= 1'b1;
    aux_power_sense_i <= sense;
    wake_on_lan_setting_i <= wake_on_lan_setting;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic brst();
    @(posedge clk_i);
    bus_rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus_rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  function automatic void build(input logic [1:0] kind, input logic [7:0] op,
                                input logic [7:0] iph);
    int s;
    s = (kind == 2'h2) ? 4 : 0;
    for (int i = 0; i < 64; i++) frm[i] = 8'h11;
    if (kind != 2'h0) begin
      for (int i = 0; i < 6; i++) frm[i] = 8'hff;
      frm[12] = 8'h81;
      frm[13] = 8'h00;
      frm[12 + s] = 8'h08;
      frm[13 + s] = 8'h06;
      frm[21 + s] = op;
      frm[40 + s] = 8'h3c;
      frm[41 + s] = iph;
      if (kind == 2'h3) frm[5] = 8'hfe;
    end
  endfunction

  task automatic frame(input logic fcs, input logic [3:0] hit, input logic slow);
    net_u.send(frm, fcs, hit, slow);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic pme_is(input logic e, input string m);
    #1;
    chk({31'h0, pme_n_o}, {31'h0, e}, m);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    #200000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial begin
    int n;
    int m;
    por(1'b1, 1'b0);
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h0, "pm after power reset");
    wb(1'b0, `FWF_ADR_STAT, 32'h0);
    chk(rd & 32'h3, 32'h0, "aux absent");
    wb(1'b0, `FWF_ADR_CTRL, 32'h0);
    chk(rd, 32'h10, "ctrl reset");
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b1, `FWF_ADR_IP, 32'h5a3c);
    $display("test reset done");
    for (int r = 0; r < 15; r++) begin
      wb(1'b1, `FWF_ADR_CTRL, {27'h0, rows[r].ctrl});
      wb(1'b1, `FWF_ADR_PM, 32'h3);
      build(rows[r].kind, rows[r].op, rows[r].iph);
      frame(rows[r].fcs, rows[r].hit, r[0]);
      pme_is(~rows[r].wake, "row wake");
      wb(1'b0, `FWF_ADR_PM, 32'h0);
      chk(rd, {30'h0, rows[r].wake, 1'b1}, "row status");
    end
    $display("test filters done");
    wb(1'b1, `FWF_ADR_CTRL, 32'h1);
    wb(1'b1, `FWF_ADR_PM, 32'h3);
    ucode_active_i <= 1'b1;
    build(2'h0, 8'h00, 8'h00);
    n = pass_cnt;
    m = store_cnt;
    frame(1'b1, 4'h1, 1'b0);
    chk(32'(pass_cnt - n), 32'h1, "engine pass");
    chk(32'(store_cnt - m), 32'h0, "store without host clock");
    pme_is(1'b0, "wake without host clock");
    @(posedge clk_i);
    host_clk_run_i <= 1'b1;
    frame(1'b1, 4'h1, 1'b1);
    chk(32'(store_cnt - m), 32'h1, "store with host clock");
    $display("test engine done");
    wb(1'b1, `FWF_ADR_PM, 32'h1);
    pme_is(1'b0, "request held");
    wb(1'b1, `FWF_ADR_PM, 32'h0);
    pme_is(1'b1, "enable cleared");
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h2, "status kept");
    wb(1'b1, `FWF_ADR_PM, 32'h2);
    frame(1'b1, 4'h1, 1'b0);
    pme_is(1'b1, "no bypass");
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h2, "status without enable");
    wb(1'b1, `FWF_ADR_PM, 32'h1);
    brst();
    pme_is(1'b1, "bus reset drops request");
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h0, "bus reset clears pm");
    $display("test hold done");
    por(1'b1, 1'b1);
    wb(1'b0, `FWF_ADR_STAT, 32'h0);
    chk(rd & 32'h3, 32'h2, "wake setting seen");
    frame(1'b1, 4'h8, 1'b0);
    pme_is(1'b0, "bypass wake");
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h2, "bypass status");
    $display("test bypass done");
    por(1'b0, 1'b0);
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h1, "armed by power reset");
    wb(1'b0, `FWF_ADR_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1, "aux present");
    frame(1'b1, 4'h8, 1'b1);
    pme_is(1'b0, "wake without setup");
    brst();
    pme_is(1'b0, "bus reset keeps request");
    wb(1'b0, `FWF_ADR_PM, 32'h0);
    chk(rd, 32'h3, "bus reset keeps pm");
    $display("test aux done");
    results();
  end
endmodule

/* src/fwf_arp_filter.sv */
`timescale 1ns/1ps
`include "fwf_consts.svh"
module fwf_arp_filter (
  input wire logic clk_i,
  input wire logic rst_i,
  fwf_rx_if.arp rx
);
  logic [5:0] cnt_r, cnt_nxt, idx, t;
  fwf_pkg::fwf_arp_flags_t f_r, f_nxt;
  // Flags: 0 dst, 1 type, 2 op, 3 ip lo, 4 ip, 5..8 same at shifted spots.
  always_comb begin
    idx = rx.sof ? 6'h00 : cnt_r;
    t = idx - `FWF_TAG_SHIFT;
    cnt_nxt = cnt_r;
    f_nxt = f_r;
    if (rx.valid) begin
      if (rx.sof) begin
        f_nxt = 9'h067;
      end
      if (idx != 6'h3f) begin
        cnt_nxt = idx + 6'h01;
      end
      if (idx <= `FWF_OFS_DST_LAST && rx.data != `FWF_VAL_BCAST) begin
        f_nxt[0] = 1'b0; // RULE_19
      end
      if ((idx == `FWF_OFS_TYPE && rx.data != `FWF_VAL_TYPE_HI) ||
          (idx == `FWF_OFS_TYPE + 6'h01 && rx.data != `FWF_VAL_TYPE_LO)) begin
        f_nxt[1] = 1'b0; // RULE_19
      end
      if (idx == `FWF_OFS_OP && rx.data != `FWF_VAL_OP) begin
        f_nxt[2] = 1'b0;
      end
      if ((t == `FWF_OFS_TYPE && rx.data != `FWF_VAL_TYPE_HI) ||
          (t == `FWF_OFS_TYPE + 6'h01 && rx.data != `FWF_VAL_TYPE_LO)) begin
        f_nxt[5] = 1'b0;
      end
      if (t == `FWF_OFS_OP && rx.data != `FWF_VAL_OP) begin
        f_nxt[6] = 1'b0;
      end
      // Only the two low address bytes are looked at, one address only.
      if (idx == `FWF_OFS_IP_LO) f_nxt[3] = (rx.data == rx.ip[7:0]); // RULE_20
      if (idx == `FWF_OFS_IP_LO + 6'h01) f_nxt[4] = f_r[3] && (rx.data == rx.ip[15:8]); // RULE_22
      if (t == `FWF_OFS_IP_LO) f_nxt[7] = (rx.data == rx.ip[7:0]);
      if (t == `FWF_OFS_IP_LO + 6'h01) f_nxt[8] = f_r[7] && (rx.data == rx.ip[15:8]);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 6'h3f;
      f_r <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
      f_r <= f_nxt;
    end
  end
  // A type other than the request type counts as tagged, tag type unchecked.
  assign rx.arp_hit = f_r[0] && ((f_r[1] && f_r[2] && f_r[4]) ||
    (rx.en[`FWF_EN_TAG] && !f_r[1] && f_r[5] && f_r[6] && f_r[8])); // RULE_17 RULE_21

  a_untag_only: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    (rx.arp_hit && !rx.en[`FWF_EN_TAG]) |-> f_r[1] && f_r[2])
    else $error("tagged request passed with tag accept off");
endmodule

/* src/fwf_consts.svh */
`ifndef FWF_CONSTS_SVH
`define FWF_CONSTS_SVH
// Contract
// [RULE_01] With aux power, power-on reset sets wake enable 1 and status 0.
// [RULE_02] Without aux power, every hardware reset clears enable and status.
// [RULE_03] With aux power, bus reset leaves enable and status untouched.
// [RULE_04] Wake setting 1 and no aux power bypasses the enable bit.
// [RULE_05] Aux sense low after reset means aux present; otherwise absent.
// [RULE_06] Wake pattern wakes after power-up without software setup.
// [RULE_07] Every frame runs through fixed filters, each with its own enable.
// [RULE_08] Wake only for frames passing an enabled filter with good FCS.
// [RULE_09] Fixed filtering runs on the local clock, host clock not needed.
// [RULE_10] Address-passed frames go to the engine; storage needs microcode and host clock.
// [RULE_11] Wake pattern frame wakes when its enable bit is set.
// [RULE_12] Unicast hit wake has its own enable bit.
// [RULE_13] Group hit wake has its own enable bit.
// [RULE_14] Broadcast destination alone never wakes.
// [RULE_15] Matching resolution request wakes when its enable bit is set.
// [RULE_16] Software keeps broadcast reception enabled for resolution wake.
// [RULE_17] Tag accept 1 passes tagged and untagged requests; 0 untagged only.
// [RULE_18] Software loads the low 16 bits of the station address.
// [RULE_19] Request needs all-ones destination, type 0806 at 12, opcode 01 at 21.
// [RULE_20] Only the two low target address bytes at 40 and 41 compare.
// [RULE_21] Tag type unchecked; other type at 12 means shifted positions.
// [RULE_22] The request filter matches one configured address only.
// [RULE_23] Any wake event sets status regardless of the enable bit.
// [RULE_24] Wake request holds until software clears status or enable.
`define FWF_ADR_CTRL 8'h00
`define FWF_ADR_IP 8'h04
`define FWF_ADR_PM 8'h08
`define FWF_ADR_STAT 8'h0c
`define FWF_EN_UNI 0
`define FWF_EN_GRP 1
`define FWF_EN_ARP 2
`define FWF_EN_TAG 3
`define FWF_EN_PAT 4
`define FWF_CTRL_RST 5'h10
`define FWF_IP_RST 16'h0000
`define FWF_PM_EN 0
`define FWF_PM_ST 1
`define FWF_OFS_DST_LAST 6'h05
`define FWF_OFS_TYPE 6'h0c
`define FWF_OFS_OP 6'h15
`define FWF_OFS_IP_LO 6'h28
`define FWF_TAG_SHIFT 6'h04
`define FWF_VAL_BCAST 8'hff
`define FWF_VAL_TYPE_HI 8'h08
`define FWF_VAL_TYPE_LO 8'h06
`define FWF_VAL_OP 8'h01
`endif

/* src/fwf_frame_gate.sv */
`timescale 1ns/1ps
`include "fwf_consts.svh"
module fwf_frame_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  fwf_rx_if.gate rx,
  output logic wake_o,
  output logic pass_o
);
  logic [3:0] hit_r, hit_nxt;
  logic eval_r, eval_nxt, fcs_r, fcs_nxt;
  always_comb begin
    hit_nxt = hit_r;
    eval_nxt = rx.valid && rx.eof;
    fcs_nxt = fcs_r;
    if (rx.valid) begin
      hit_nxt = (rx.sof ? 4'h0 : hit_r) | rx.hit;
      if (rx.eof) fcs_nxt = rx.fcs_ok;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_r <= 4'h0;
      eval_r <= 1'b0;
      fcs_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
      eval_r <= eval_nxt;
      fcs_r <= fcs_nxt;
    end
  end
  // Hit order: 0 unicast, 1 group, 2 broadcast, 3 wake pattern.
  // Broadcast alone is never a wake cause; it only reaches the engine.
  assign wake_o = eval_r && fcs_r && // RULE_08 RULE_14
    ((hit_r[0] && rx.en[`FWF_EN_UNI]) || // RULE_12
     (hit_r[1] && rx.en[`FWF_EN_GRP]) || // RULE_13
     (rx.arp_hit && rx.en[`FWF_EN_ARP]) || // RULE_15
     (hit_r[3] && rx.en[`FWF_EN_PAT])); // RULE_11
  assign pass_o = eval_r && fcs_r && (|hit_r[2:0] || rx.arp_hit); // RULE_10

  a_bcast_no_wake: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
    (hit_r == 4'h4 && !rx.arp_hit) |-> !wake_o)
    else $error("broadcast hit alone raised a wake");
endmodule

/* src/fwf_pkg.sv */
package fwf_pkg;
  typedef enum logic [1:0] {FWF_RS_POR, FWF_RS_BUS, FWF_RS_RUN} fwf_rst_state_t;
  typedef logic [8:0] fwf_arp_flags_t;
endpackage

/* src/fwf_rx_if.sv */
`timescale 1ns/1ps
interface fwf_rx_if;
  logic valid;
  logic [7:0] data;
  logic sof;
  logic eof;
  logic fcs_ok;
  logic [3:0] hit;
  logic [15:0] ip;
  logic [4:0] en;
  logic arp_hit;
  modport src (output valid, data, sof, eof, fcs_ok, hit, ip, en, input arp_hit);
  modport arp (input valid, data, sof, ip, en, output arp_hit);
  modport gate (input valid, sof, eof, fcs_ok, hit, en, arp_hit);
endinterface

/* src/fwf_top.sv */
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "fwf_consts.svh"
module fwf_top (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive stream and address filter results
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  input wire logic rx_fcs_ok_i,
  input wire logic rx_ia_match_i,
  input wire logic rx_mc_match_i,
  input wire logic rx_bc_match_i,
  input wire logic rx_pattern_match_i,
  // Straps and engine status
  input wire logic aux_power_sense_i,
  input wire logic wake_on_lan_setting_i,
  input wire logic ucode_active_i,
  input wire logic host_clk_run_i,
  // Wake request and engine hand-off
  output logic pme_n_o,
  output logic engine_pass_o,
  output logic engine_store_o
);

  // ==========================================================
  // Frame filtering
  // ==========================================================
  // Everything here runs from the local clock, so filtering keeps
  // going in every power state whether the host clock runs or not.
  fwf_rx_if rx ();

  logic [4:0] ctrl_r, ctrl_nxt;
  logic [15:0] ip_r, ip_nxt;
  logic wake_evt;
  logic gate_pass;
  logic pm_en_r, pm_en_nxt;
  logic pm_st_r, pm_st_nxt;
  logic [7:0] wake_cnt_r, wake_cnt_nxt;

  assign rx.valid = rx_valid_i; // RULE_07 RULE_09
  assign rx.data = rx_data_i;
  assign rx.sof = rx_sof_i;
  assign rx.eof = rx_eof_i;
  assign rx.fcs_ok = rx_fcs_ok_i;
  assign rx.hit = {rx_pattern_match_i, rx_bc_match_i, rx_mc_match_i, rx_ia_match_i};
  assign rx.ip = ip_r;
  assign rx.en = ctrl_r;

  fwf_arp_filter u_arp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx(rx.arp)
  );

  fwf_frame_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx(rx.gate),
    .wake_o(wake_evt),
    .pass_o(gate_pass)
  );

  // ==========================================================
  // Reset sequencing and strap sampling
  // ==========================================================
  // The aux sense pin is caught one clock after a reset is released,
  // never under reset, so the flop itself resets to a constant.
  fwf_pkg::fwf_rst_state_t rs_r, rs_nxt;
  logic aux_r, aux_nxt;
  logic wol_r, wol_nxt;
  logic sample;
  logic arm;
  logic bus_clr;

  always_comb begin
    rs_nxt = rs_r;
    sample = 1'b0;
    arm = 1'b0;
    case (rs_r)
      fwf_pkg::FWF_RS_POR: begin
        if (bus_rst_n_i) begin
          sample = 1'b1;
          arm = 1'b1;
          rs_nxt = fwf_pkg::FWF_RS_RUN;
        end
      end
      fwf_pkg::FWF_RS_BUS: begin
        if (bus_rst_n_i) begin
          sample = 1'b1;
          rs_nxt = fwf_pkg::FWF_RS_RUN;
        end
      end
      fwf_pkg::FWF_RS_RUN: begin
        if (!bus_rst_n_i) begin
          rs_nxt = fwf_pkg::FWF_RS_BUS;
        end
      end
      default: begin
        rs_nxt = fwf_pkg::FWF_RS_RUN;
      end
    endcase
    // A low sense level after reset means aux power is present.
    aux_nxt = sample ? !aux_power_sense_i : aux_r; // RULE_05
    wol_nxt = sample ? wake_on_lan_setting_i : wol_r;
    // Bus reset only touches the wake bits when aux power is absent.
    bus_clr = !bus_rst_n_i && (rs_r != fwf_pkg::FWF_RS_POR) && !aux_r; // RULE_02 RULE_03
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_r <= fwf_pkg::FWF_RS_POR;
      aux_r <= 1'b0;
      wol_r <= 1'b0;
    end else begin
      rs_r <= rs_nxt;
      aux_r <= aux_nxt;
      wol_r <= wol_nxt;
    end
  end

  // ==========================================================
  // Wishbone register slave
  // ==========================================================
  // Every access is acked one cycle after the request; unmapped
  // addresses read zero and ignore writes rather than stall the bus.
  // A write lands on the edge that sees ack high, the same edge at which
  // the master completes, so a request withdrawn early changes nothing.
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic req;
  logic wr;
  logic pm_wr;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i;
  assign pm_wr = wr && (wb_adr_i == `FWF_ADR_PM) && wb_sel_i[0];

  always_comb begin
    ack_nxt = req;
    dat_nxt = dat_r;
    ctrl_nxt = ctrl_r;
    ip_nxt = ip_r;
    if (req) begin
      dat_nxt = 32'h0000_0000;
      case (wb_adr_i)
        `FWF_ADR_CTRL: dat_nxt[4:0] = ctrl_r;
        `FWF_ADR_IP: dat_nxt[15:0] = ip_r;
        `FWF_ADR_PM: dat_nxt[1:0] = {pm_st_r, pm_en_r};
        `FWF_ADR_STAT: dat_nxt[15:0] = {wake_cnt_r, 5'h00, !pme_n_o, wol_r, aux_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    if (wr && wb_adr_i == `FWF_ADR_CTRL && wb_sel_i[0]) begin
      ctrl_nxt = wb_dat_i[4:0]; // RULE_07
    end
    if (wr && wb_adr_i == `FWF_ADR_IP) begin
      if (wb_sel_i[0]) ip_nxt[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) ip_nxt[15:8] = wb_dat_i[15:8];
    end
    // Configuration is function context and follows the bus reset.
    if (!bus_rst_n_i) begin
      ctrl_nxt = `FWF_CTRL_RST;
      ip_nxt = `FWF_IP_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      ctrl_r <= `FWF_CTRL_RST; // RULE_06
      ip_r <= `FWF_IP_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      ip_r <= ip_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================
  // Wake enable, status and request
  // ==========================================================
  logic pme_n_r, pme_n_nxt;
  logic pass_r, store_r;
  logic bypass_nxt;

  always_comb begin
    pm_en_nxt = pm_en_r;
    pm_st_nxt = pm_st_r;
    wake_cnt_nxt = wake_cnt_r;
    if (pm_wr) begin
      pm_en_nxt = wb_dat_i[`FWF_PM_EN];
      if (wb_dat_i[`FWF_PM_ST]) pm_st_nxt = 1'b0;
    end
    // Arming happens once, on leaving power-on reset, without software.
    if (arm && !aux_power_sense_i) begin
      pm_en_nxt = 1'b1; // RULE_01
      pm_st_nxt = 1'b0;
    end
    // The event beats a software clear in the same cycle.
    if (wake_evt) begin
      pm_st_nxt = 1'b1; // RULE_23
      if (wake_cnt_r != 8'hff) wake_cnt_nxt = wake_cnt_r + 8'h01;
    end
    if (bus_clr) begin
      pm_en_nxt = 1'b0; // RULE_02
      pm_st_nxt = 1'b0;
    end
    bypass_nxt = wol_nxt && !aux_nxt; // RULE_04
    // The request stays until status or the effective enable drops.
    pme_n_nxt = !(pm_st_nxt && (pm_en_nxt || bypass_nxt)); // RULE_24
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_en_r <= 1'b0;
      pm_st_r <= 1'b0;
      pme_n_r <= 1'b1;
      wake_cnt_r <= 8'h00;
      pass_r <= 1'b0;
      store_r <= 1'b0;
    end else begin
      pm_en_r <= pm_en_nxt;
      pm_st_r <= pm_st_nxt;
      pme_n_r <= pme_n_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      pass_r <= gate_pass; // RULE_10
      store_r <= gate_pass && ucode_active_i && host_clk_run_i; // RULE_10
    end
  end

  assign pme_n_o = pme_n_r;
  assign engine_pass_o = pass_r;
  assign engine_store_o = store_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_por_arm_aux: assert property ( // RULE_01
    (!rst_i && rs_r == fwf_pkg::FWF_RS_POR && bus_rst_n_i && !aux_power_sense_i && !wake_evt)
    |=> pm_en_r && !pm_st_r && aux_r)
    else $error("power-on with aux power did not arm wake");

  a_bus_clr_noaux: assert property ( // RULE_02
    (!bus_rst_n_i && rs_r == fwf_pkg::FWF_RS_RUN && !aux_r)
    |=> !pm_en_r && !pm_st_r && pme_n_o)
    else $error("bus reset without aux power kept wake bits");

  a_bus_keep_aux: assert property ( // RULE_03
    (!bus_rst_n_i && rs_r != fwf_pkg::FWF_RS_POR && aux_r && !pm_wr && !wake_evt)
    |=> $stable(pm_en_r) && $stable(pm_st_r))
    else $error("bus reset with aux power changed wake bits");

  a_wol_bypass: assert property ( // RULE_04
    (pm_st_r && wol_r && !aux_r) |-> !pme_n_o)
    else $error("wake setting did not bypass the enable");

  a_no_bypass: assert property ( // RULE_04
    (!pm_en_r && !(wol_r && !aux_r)) |-> pme_n_o)
    else $error("wake request without enable or bypass");

  a_aux_sample: assert property ( // RULE_05
    (!rst_i && rs_r != fwf_pkg::FWF_RS_RUN && bus_rst_n_i)
    |=> rs_r == fwf_pkg::FWF_RS_RUN && aux_r == !$past(aux_power_sense_i))
    else $error("aux sense not sampled on reset release");

  a_wake_status: assert property ( // RULE_23
    (wake_evt && !bus_clr) |=> pm_st_r)
    else $error("wake event did not set status");

  a_fcs_wake: assert property ( // RULE_08
    wake_evt |-> $past(rx_valid_i && rx_eof_i && rx_fcs_ok_i))
    else $error("wake event without good frame check");

  a_store_gate: assert property ( // RULE_10
    engine_store_o |-> engine_pass_o && $past(ucode_active_i && host_clk_run_i))
    else $error("frame stored without microcode or host clock");

  a_req_hold: assert property ( // RULE_24
    (!pme_n_o && !pm_wr && bus_rst_n_i && rs_r == fwf_pkg::FWF_RS_RUN)
    |=> !pme_n_o)
    else $error("wake request dropped without a clear");

  a_ack_pulse: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");

  // The sampled reset is part of the a_por_arm_aux and a_aux_sample antecedents, because the edge
  // that releases reset still shows the design held in reset.
  a_noaux_por_clear: assert property ( // RULE_02
    ($past(rst_i) && !rst_i && bus_rst_n_i && aux_power_sense_i && !wake_evt)
    |=> !pm_en_r && !pm_st_r)
    else $error("power-on without aux power left wake bits set");

  a_cfg_bus_rst: assert property (
    !bus_rst_n_i |=> ctrl_r == `FWF_CTRL_RST && ip_r == `FWF_IP_RST)
    else $error("bus reset kept the filter configuration");

  a_pass_fcs: assert property ( // RULE_08
    engine_pass_o |-> $past(rx_valid_i && rx_eof_i && rx_fcs_ok_i, 2))
    else $error("engine pass without good frame check");

  a_wake_count: assert property ( // RULE_23
    (wake_evt && wake_cnt_r != 8'hff) |=> wake_cnt_r == $past(wake_cnt_r) + 8'h01)
    else $error("wake event not counted");

  a_st_clear: assert property (
    (pm_wr && wb_dat_i[`FWF_PM_ST] && !wake_evt) |=> !pm_st_r)
    else $error("software status clear was lost");

  c_por_arm: cover property (
    rs_r == fwf_pkg::FWF_RS_POR ##1 pm_en_r);

  c_arp_wake: cover property (
    wake_evt && rx.arp_hit && ctrl_r[`FWF_EN_ARP] ##1 !pme_n_o);

  c_bypass_wake: cover property (
    wake_evt && !pm_en_r && wol_r && !aux_r ##1 !pme_n_o);

  c_bus_keep: cover property (
    !bus_rst_n_i && aux_r && pm_en_r ##1 pm_en_r);

  c_bus_clear: cover property (
    !bus_rst_n_i && !aux_r && pm_en_r ##1 !pm_en_r);

endmodule
